// ---- logic/asr_pkg.sv ----
// Constants for the asynchronous serial receiver
// Functional notes
// - Sample the line at sixteen times the bit rate; shift once per bit.
// - Move a full 8- or 9-bit character at once into a two-deep FIFO.
// - Falling edge starts reception; recheck line low at half a bit.
// - Start bit high at midpoint: abandon silently, look for edge again.
// - Each later bit sampled one bit apart by majority vote, shifted in.
// - Stop bit sampled one bit after data; low sets framing error, high clears.
// - After stop bit, write character into FIFO and raise pending flag.
// - Reading the data register returns oldest character and pops it.
// - Polarity control zero is true data; one inverts the line in async mode.
// - Pending flag high exactly while enabled with an unread character.
// - Interrupt only when receive, peripheral and global enables are all set.
// - Framing error stored per entry; status shows oldest unread entry.
// - Framing error never blocks reception nor interrupts; read-only, no clear.
// - Port enable clear resets block and framing error; receiver enable does not.
// - Third character with FIFO full sets overrun and blocks further reception.
// - Clearing receiver or port enable clears overrun; software must do so.
// - Nine-bit mode shifts nine bits; ninth bit of oldest entry shown apart.
// - Address detect in nine-bit mode keeps only characters whose ninth bit is set.
package asr_pkg;
  localparam int unsigned OVERSAMPLE = 16;
  localparam logic [3:0] HALF_BIT_TICKS = 4'h7;
  localparam logic [3:0] FULL_BIT_TICKS = 4'hF;
  localparam logic [3:0] DATA_BITS_8 = 4'h8;
  localparam logic [3:0] DATA_BITS_9 = 4'h9;
  localparam int unsigned FIFO_DEPTH = 2;
  localparam logic [1:0] FIFO_CNT_FULL = 2'h2;
  localparam logic [8:0] SHIFT_RESET = 9'h000;

  typedef enum logic [1:0] {
    ASR_IDLE = 2'b00,
    ASR_START = 2'b01,
    ASR_DATA = 2'b10,
    ASR_STOP = 2'b11
  } asr_state_e;
endpackage

// ---- logic/asr_receiver.sv ----
// Asynchronous serial receiver with two-deep FIFO and address filtering
`timescale 1ns/1ps
module asr_receiver (
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic baud_tick16,
  input wire logic serial_rx_pin,
  input wire logic port_enable,
  input wire logic rx_enable,
  input wire logic sync_mode,
  input wire logic nine_bit_rx_select,
  input wire logic address_detect_enable,
  input wire logic rx_polarity_invert,
  input wire logic rx_irq_enable,
  input wire logic peripheral_irq_enable,
  input wire logic global_irq_enable,
  input wire logic rx_data_read,
  output logic [7:0] rx_data_reg,
  output logic rx_ninth_bit,
  output logic framing_error,
  output logic overrun_error,
  output logic rx_pending_flag,
  output logic rx_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Line conditioning
  logic line_reg;
  logic line_prev_reg;
  logic [2:0] vote_reg;
  logic line_now;
  logic vote_bit;
  logic active;

  // Polarity applies in async mode only
  // line inversion
  assign line_now = (rx_polarity_invert & ~sync_mode) ? ~serial_rx_pin : serial_rx_pin;
  assign active = port_enable & rx_enable & ~sync_mode;

  // Reset to the idle level so no false edge follows reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      line_reg <= 1'b1;
      line_prev_reg <= 1'b1;
    end else if (clk_en) begin
      line_reg <= line_now;
      line_prev_reg <= line_reg;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      vote_reg <= 3'h7;
    end else if (clk_en) begin
      if (baud_tick16) begin
        vote_reg <= {vote_reg[1:0], line_reg};
      end
    end
  end

  assign vote_bit = (vote_reg[0] & vote_reg[1]) | (vote_reg[1] & vote_reg[2]) |
                    (vote_reg[0] & vote_reg[2]);

  ////////////////////////////////////////////////////////////////////////////
  // Bit recovery state machine
  asr_pkg::asr_state_e state_reg;
  logic [3:0] tick_reg;
  logic [3:0] bit_cnt_reg;
  logic [8:0] rx_shift_reg;
  logic char_done;
  logic char_framing_error;
  logic [8:0] char_data;
  logic [3:0] bits_needed;

  assign bits_needed = nine_bit_rx_select ? asr_pkg::DATA_BITS_9 : asr_pkg::DATA_BITS_8;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= asr_pkg::ASR_IDLE;
      tick_reg <= 4'h0;
      bit_cnt_reg <= 4'h0;
      rx_shift_reg <= asr_pkg::SHIFT_RESET;
      char_done <= 1'b0;
      char_framing_error <= 1'b0;
      char_data <= asr_pkg::SHIFT_RESET;
    end else if (clk_en) begin
      char_done <= 1'b0;
      if (!active || overrun_error) begin
        state_reg <= asr_pkg::ASR_IDLE;
        tick_reg <= 4'h0;
        bit_cnt_reg <= 4'h0;
        if (!port_enable) begin
          rx_shift_reg <= asr_pkg::SHIFT_RESET;
        end
      end else begin
        unique case (state_reg)
          asr_pkg::ASR_IDLE: begin
            if (line_prev_reg && !line_reg) begin
              state_reg <= asr_pkg::ASR_START;
              tick_reg <= 4'h0;
            end
          end
          asr_pkg::ASR_START: begin
            if (baud_tick16) begin
              if (tick_reg == asr_pkg::HALF_BIT_TICKS) begin
                tick_reg <= 4'h0;
                bit_cnt_reg <= 4'h0;
                state_reg <= vote_bit ? asr_pkg::ASR_IDLE : asr_pkg::ASR_DATA;
              end else begin
                tick_reg <= tick_reg + 4'h1;
              end
            end
          end
          asr_pkg::ASR_DATA: begin
            if (baud_tick16) begin
              if (tick_reg == asr_pkg::FULL_BIT_TICKS) begin
                tick_reg <= 4'h0;
                // LSB first; nine bits land MSB at bit 8
                if (nine_bit_rx_select) begin
                  rx_shift_reg <= {vote_bit, rx_shift_reg[8:1]};
                end else begin
                  rx_shift_reg <= {1'b0, vote_bit, rx_shift_reg[7:1]};
                end
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                if (bit_cnt_reg + 4'h1 == bits_needed) begin
                  state_reg <= asr_pkg::ASR_STOP;
                end
              end else begin
                tick_reg <= tick_reg + 4'h1;
              end
            end
          end
          asr_pkg::ASR_STOP: begin
            if (baud_tick16) begin
              if (tick_reg == asr_pkg::FULL_BIT_TICKS) begin
                tick_reg <= 4'h0;
                // stop bit sets or clears error
                char_framing_error <= ~vote_bit;
                char_data <= rx_shift_reg;
                char_done <= 1'b1;
                state_reg <= asr_pkg::ASR_IDLE;
              end else begin
                tick_reg <= tick_reg + 4'h1;
              end
            end
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive FIFO, two entries with per-entry framing error
  logic [8:0] fifo_data [asr_pkg::FIFO_DEPTH];
  logic [1:0] fifo_framing_error;
  logic [1:0] count_reg;
  logic accept;
  logic pop;
  logic push;

  // in nine-bit mode the address filter keeps ninth-bit characters only
  assign accept = ~(address_detect_enable & nine_bit_rx_select & ~char_data[8]);
  assign pop = rx_data_read & (count_reg != 2'h0);
  // push after stop
  // A pop in the same cycle frees a slot, so a full FIFO still takes the character
  assign push = char_done & accept & ((count_reg != asr_pkg::FIFO_CNT_FULL) | pop);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_reg <= 2'h0;
    end else if (clk_en) begin
      if (!port_enable) begin
        count_reg <= 2'h0;
      end else begin
        count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
      end
    end
  end

  // Data storage is not cleared with the port off; the zero count hides it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fifo_data[0] <= asr_pkg::SHIFT_RESET;
      fifo_data[1] <= asr_pkg::SHIFT_RESET;
      fifo_framing_error <= 2'h0;
    end else if (clk_en) begin
      if (!port_enable) begin
        fifo_framing_error <= 2'h0;
      end else begin
        if (pop) begin
          fifo_data[0] <= fifo_data[1];
          fifo_framing_error[0] <= fifo_framing_error[1];
        end
        if (push) begin
          if (pop ? (count_reg == 2'h2) : (count_reg == 2'h1)) begin
            fifo_data[1] <= char_data;
            fifo_framing_error[1] <= char_framing_error;
          end else begin
            fifo_data[0] <= char_data;
            fifo_framing_error[0] <= char_framing_error;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Overrun
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      overrun_error <= 1'b0;
    end else if (clk_en) begin
      if (!port_enable || !rx_enable) begin
        overrun_error <= 1'b0;
      end else if (char_done && accept && count_reg == asr_pkg::FIFO_CNT_FULL && !pop) begin
        overrun_error <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status outputs, registered from next FIFO state
  logic [1:0] count_next;
  logic [8:0] head_next;
  logic framing_error_next;

  // Mirrors FIFO update so outputs line up with the entry they describe
  always_comb begin
    count_next = count_reg + {1'b0, push} - {1'b0, pop};
    if (!port_enable) begin
      count_next = 2'h0;
    end
    if (pop) begin
      head_next = (count_reg == 2'h1) ? char_data : fifo_data[1];
      framing_error_next = (count_reg == 2'h1) ? char_framing_error : fifo_framing_error[1];
    end else if (count_reg == 2'h0) begin
      head_next = char_data;
      framing_error_next = char_framing_error;
    end else begin
      head_next = fifo_data[0];
      framing_error_next = fifo_framing_error[0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_data_reg <= 8'h00;
      rx_ninth_bit <= 1'b0;
    end else if (clk_en) begin
      rx_data_reg <= head_next[7:0];
      rx_ninth_bit <= head_next[8] & (count_next != 2'h0);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      framing_error <= 1'b0;
    end else if (clk_en) begin
      framing_error <= framing_error_next & (count_next != 2'h0);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_pending_flag <= 1'b0;
    end else if (clk_en) begin
      rx_pending_flag <= rx_enable & (count_next != 2'h0);
    end
  end

  // all three enables gate the request
  // Built from the next FIFO state so the request rises with the flag
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_irq <= 1'b0;
    end else if (clk_en) begin
      rx_irq <= rx_enable & (count_next != 2'h0) & rx_irq_enable &
                peripheral_irq_enable & global_irq_enable;
    end
  end

endmodule

// ---- sim/asr_receiver_properties.sv ----
// Port checks for the asynchronous serial receiver
`timescale 1ns/1ps
module asr_receiver_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic port_enable,
  input wire logic rx_enable,
  input wire logic rx_irq_enable,
  input wire logic peripheral_irq_enable,
  input wire logic global_irq_enable,
  input wire logic rx_data_read,
  input wire logic framing_error,
  input wire logic overrun_error,
  input wire logic rx_pending_flag,
  input wire logic rx_irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////////
  a_pend_needs_en: assert property (
    clk_en && !rx_enable |=> !rx_pending_flag) else $error("pending while disabled");
  a_pend_rise_en: assert property (
    $rose(rx_pending_flag) |-> $past(rx_enable)) else $error("pending rose unenabled");
  a_irq_gate_all: assert property (
    clk_en && !(rx_irq_enable && peripheral_irq_enable && global_irq_enable) |=> !rx_irq)
    else $error("irq without all enables");
  a_port_off_clears: assert property (
    clk_en && !port_enable |=> !rx_pending_flag && !overrun_error && !framing_error)
    else $error("port off did not clear");
  a_rx_off_ovr: assert property (
    clk_en && !rx_enable |=> !overrun_error) else $error("overrun not cleared");
  a_ovr_sticky: assert property (
    overrun_error && clk_en && rx_enable && port_enable |=> overrun_error)
    else $error("overrun dropped");
  a_ovr_needs_full: assert property (
    $rose(overrun_error) |-> $past(rx_pending_flag)) else $error("overrun while empty");
  // Reads may show one or two cycles later, so both depths are allowed
  a_fe_holds_head: assert property (
    $changed(framing_error) |-> $past(rx_data_read) || $past(rx_data_read, 2)
      || !$past(port_enable) || !$past(rx_pending_flag)) else $error("framing changed alone");
  c_overrun: cover property ($rose(overrun_error));
  c_framing: cover property (framing_error && rx_pending_flag);
  c_irq: cover property ($rose(rx_irq));
endmodule

// ---- sim/asr_tx_model.sv ----
// Remote transmitter model that drives the serial line
`timescale 1ns/1ps
module asr_tx_model (
  input wire logic clk,
  input wire logic inv,
  output logic line
);
  logic lvl = 1'b1;
  assign line = lvl ^ inv;
  task automatic send(input logic [8:0] d, input int nb, input logic stop, input int bclk);
    lvl <= 1'b0;
    repeat (bclk) @(negedge clk);
    for (int i = 0; i <= nb; i++) begin
      lvl <= (i == nb) ? stop : d[i];
      repeat (bclk) @(negedge clk);
    end
    lvl <= 1'b1;
    repeat (bclk) @(negedge clk);
  endtask
  task automatic pulse(input int n);
    lvl <= 1'b0;
    repeat (n) @(negedge clk);
    lvl <= 1'b1;
  endtask
endmodule

// ---- sim/tb.sv ----
// Self-checking bench for the asynchronous serial receiver
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
  $display("Error %s exp %h got %h", n, e, g); end end
module tb;
  localparam int BCLK = 32;
  logic clk = 0, rst = 1, clk_en = 1, tick = 0, sync = 0, rd = 0, line;
  logic port_en = 0, rx_en = 0, nine = 0, addr = 0, inv = 0, ie = 0, pe = 0, ge = 0;
  logic [7:0] data;
  logic ninth, fe, ovr, pend, irq, m_ovr = 0;
  logic [9:0] q[$];
  logic [31:0] seed = 32'hA99D8712;
  int miscompares = 0, n_compared = 0;
  initial forever #20 clk = ~clk;
  // Tick every other cycle gives a 32-cycle bit
  always @(negedge clk) tick <= ~tick;
  asr_receiver i_asr_receiver (.clk, .rst, .clk_en, .baud_tick16(tick), .serial_rx_pin(line),
    .port_enable(port_en), .rx_enable(rx_en), .sync_mode(sync), .nine_bit_rx_select(nine),
    .address_detect_enable(addr), .rx_polarity_invert(inv), .rx_irq_enable(ie),
    .peripheral_irq_enable(pe), .global_irq_enable(ge), .rx_data_read(rd),
    .rx_data_reg(data), .rx_ninth_bit(ninth), .framing_error(fe), .overrun_error(ovr),
    .rx_pending_flag(pend), .rx_irq(irq));
  asr_tx_model i_asr_tx_model (.clk, .inv, .line);
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic tx(input logic b8, input logic stop);
    logic [8:0] d;
    seed = lfsr(seed);
    d = {b8, seed[7:0]};
    i_asr_tx_model.send(d, nine ? 9 : 8, stop, BCLK);
    if (!(m_ovr || sync || (addr && !d[8]))) begin
      if (q.size() == 2) m_ovr = 1;
      else q.push_back({~stop, nine & d[8], d[7:0]});
    end
    repeat (4) @(negedge clk);
    `CHK("pend", q.size() != 0, pend)
    `CHK("ovr", m_ovr, ovr)
  endtask
  task automatic pop();
    `CHK("fe", q[0][9], fe)
    `CHK("ninth", q[0][8], ninth)
    `CHK("data", q[0][7:0], data)
    rd = 1;
    @(negedge clk);
    rd = 0;
    void'(q.pop_front());
    repeat (3) @(negedge clk);
  endtask
  task automatic tally_and_finish();
    $display("Compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    tally_and_finish();
  end
  initial begin
    repeat (5) @(negedge clk);
    rst = 0;
    port_en = 1;
    rx_en = 1;
    repeat (BCLK) @(negedge clk);
    tx(0, 0);
    tx(0, 1);
    pop();
    pop();
    $display("Test basic done");
    repeat (4) tx(0, 1);
    pop();
    pop();
    `CHK("ovr", 1'b1, ovr)
    rx_en = 0;
    m_ovr = 0;
    repeat (2) @(negedge clk);
    `CHK("ovr", 1'b0, ovr)
    rx_en = 1;
    $display("Test overrun done");
    tx(0, 1);
    for (int m = 0; m < 8; m++) begin
      {ie, pe, ge} = m[2:0];
      repeat (2) @(negedge clk);
      `CHK("irq", m == 7, irq)
    end
    {ie, pe, ge} = 3'h0;
    pop();
    $display("Test irq done");
    inv = 1;
    nine = 1;
    addr = 1;
    repeat (BCLK) @(negedge clk);
    tx(0, 1);
    tx(1, 1);
    addr = 0;
    tx(0, 0);
    pop();
    pop();
    inv = 0;
    nine = 0;
    $display("Test address done");
    i_asr_tx_model.pulse(6);
    repeat (12 * BCLK) @(negedge clk);
    `CHK("pend", 1'b0, pend)
    sync = 1;
    tx(0, 1);
    sync = 0;
    tx(0, 1);
    // Read while frozen must not pop
    clk_en = 0;
    rd = 1;
    @(negedge clk);
    rd = 0;
    clk_en = 1;
    `CHK("pend", 1'b1, pend)
    pop();
    $display("Test false start done");
    tx(0, 0);
    rx_en = 0;
    repeat (2) @(negedge clk);
    `CHK("fe", 1'b1, fe)
    port_en = 0;
    q.delete();
    repeat (2) @(negedge clk);
    `CHK("fe", 1'b0, fe)
    `CHK("pend", 1'b0, pend)
    $display("Test port off done");
    tally_and_finish();
  end
endmodule
bind asr_receiver asr_receiver_properties i_asr_receiver_properties (.clk, .rst, .clk_en,
  .port_enable, .rx_enable, .rx_irq_enable, .peripheral_irq_enable, .global_irq_enable,
  .rx_data_read, .framing_error, .overrun_error, .rx_pending_flag, .rx_irq);
